// ==== hdl/brc_ctrl.sv ====
// Host controller that reads and writes a 256 x 1 asynchronous RAM with an inverting three-state output.
// Assumes a 200 MHz mclk and that the RAM pins are wired straight to the ports below.
// Summary of operation
// - Address is stable and valid before the write strobe pulse begins.
// - Chip selects are asserted before the write strobe pulse begins.
// - Data input is valid before the write strobe pulse ends.
// - Data input stays valid until after the write strobe pulse ends.
// - Address stays stable until the write strobe pulse has ended.
// - Chip selects stay asserted until the write strobe pulse has ended.
`timescale 1ns/1ps
module brc_ctrl
	import brc_pkg::*;
(
	input  wire logic                       mclk,
	input  wire logic                       resetn,
	input  wire logic                       clkEn,
	input  wire logic                       reqValid,
	output logic                            reqReady,
	input  wire logic                       reqWrite,
	input  wire logic [brc_pkg::ADDR_W-1:0] reqAddr,
	input  wire logic                       reqData,
	output logic                            rspValid,
	output logic                            rspData,
	output logic                            wrCheckErr,
	output logic [brc_pkg::ADDR_W-1:0]      ramAddr,
	output logic [brc_pkg::CE_N-1:0]        ramCeN,
	output logic                            ramWeN,
	output logic                            ramDin,
	input  wire logic                       ramDoutN
);
	import brc_pkg::*;
	logic rst1_q, rstN_q;
	logic rst1_d, rstN_d;

	always_comb begin
		rst1_d = 1'b1;
		rstN_d = rst1_q;
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rst1_q <= 1'b0;
			rstN_q <= 1'b0;
		end else begin
			rst1_q <= rst1_d;
			rstN_q <= rstN_d;
		end
	end

	brc_sync_if sif ();
	assign sif.rawIn = ramDoutN;
	brc_sync u_sync (
		.mclk  (mclk),
		.rstN  (rstN_q),
		.clkEn (clkEn),
		.sif   (sif)
	);

	brc_state_t                 state_q, state_d;
	logic [CNT_W-1:0]           cnt_q, cnt_d;
	logic                       isWrite_q, isWrite_d;
	logic [ADDR_W-1:0]          addr_q, addr_d;
	logic [CE_N-1:0]            ce_q, ce_d;
	logic                       we_q, we_d;
	logic                       din_q, din_d;
	logic                       rspValid_q, rspValid_d;
	logic                       rspData_q, rspData_d;
	logic                       err_q, err_d;
	logic                       cntDone;

	assign cntDone = (cnt_q == CNT_ONE);

	always_comb begin
		state_d    = state_q;
		cnt_d      = (cnt_q != CNT_ZERO) ? cnt_q - CNT_ONE : CNT_ZERO;
		isWrite_d  = isWrite_q;
		addr_d     = addr_q;
		ce_d       = ce_q;
		we_d       = we_q;
		din_d      = din_q;
		if (clkEn) begin
			case (state_q)
				ST_IDLE: begin
					if (reqValid) begin
						addr_d    = reqAddr;
						din_d     = reqData;
						isWrite_d = reqWrite;
						ce_d      = CE_ON;
						we_d      = 1'b1;
						if (reqWrite) begin
							state_d = ST_SETUP;
							cnt_d   = SET_CYC;
						end else begin
							state_d = ST_ACCESS;
							cnt_d   = ACC_CYC + SYNC_CYC;
						end
					end
				end
				ST_SETUP: begin
					if (cntDone) begin
						we_d    = 1'b0;
						state_d = ST_PULSE;
						cnt_d   = PULSE_CYC + SYNC_CYC;
					end
				end
				ST_PULSE: begin
					if (cntDone) begin
						we_d    = 1'b1;
						state_d = ST_HOLD;
						cnt_d   = HOLD_CYC;
					end
				end
				ST_HOLD: begin
					if (cntDone) begin
						ce_d    = CE_OFF;
						state_d = ST_RECOVER;
						cnt_d   = OFF_CYC;
					end
				end
				ST_ACCESS: begin
					if (cntDone) begin
						ce_d       = CE_OFF;
						state_d    = ST_RECOVER;
						cnt_d      = OFF_CYC;
					end
				end
				ST_RECOVER: begin
					if (cntDone) begin
						state_d    = ST_IDLE;
					end
				end
				default: begin
					state_d = ST_IDLE;
				end
			endcase
		end else begin
			cnt_d = cnt_q;
		end
	end

	always_ff @(posedge mclk or negedge rstN_q) begin
		if (!rstN_q) begin
			state_q    <= ST_IDLE;
			cnt_q      <= CNT_ZERO;
			isWrite_q  <= 1'b0;
			addr_q     <= '0;
			ce_q       <= CE_OFF;
			we_q       <= 1'b1;
			din_q      <= 1'b0;
		end else begin
			state_q    <= state_d;
			cnt_q      <= cnt_d;
			isWrite_q  <= isWrite_d;
			addr_q     <= addr_d;
			ce_q       <= ce_d;
			we_q       <= we_d;
			din_q      <= din_d;
		end
	end

	// Response pulses hold while clkEn is low so that a frozen host does not lose them.
	always_comb begin
		rspValid_d = 1'b0;
		rspData_d  = rspData_q;
		err_d      = 1'b0;
		if (!clkEn) begin
			rspValid_d = rspValid_q;
			err_d      = err_q;
		end else if (cntDone) begin
			case (state_q)
				ST_PULSE: begin
					err_d = (sif.syncOut == din_q);
				end
				ST_ACCESS: begin
					rspValid_d = 1'b1;
					rspData_d  = ~sif.syncOut;
				end
				ST_RECOVER: begin
					rspValid_d = isWrite_q;
				end
				default: begin
					rspValid_d = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rstN_q) begin
		if (!rstN_q) begin
			rspValid_q <= 1'b0;
			rspData_q  <= 1'b0;
			err_q      <= 1'b0;
		end else begin
			rspValid_q <= rspValid_d;
			rspData_q  <= rspData_d;
			err_q      <= err_d;
		end
	end

	assign reqReady   = (state_q == ST_IDLE) && clkEn && rstN_q;
	assign rspValid   = rspValid_q;
	assign rspData    = rspData_q;
	assign wrCheckErr = err_q;
	assign ramAddr    = addr_q;
	assign ramCeN     = ce_q;
	assign ramWeN     = we_q;
	assign ramDin     = din_q;
endmodule

// ==== pkg/brc_pkg.sv ====
// Package for the bit RAM host controller: pin widths, timing figures and cycle counts.
// Assumes a 200 MHz mclk.
package brc_pkg;
	localparam int ADDR_W     = 8;
	localparam int CELLS      = 256;
	localparam int CE_N       = 3;
	localparam int CLK_PS     = 5000;
	// Least times in ns for the write cycle and read access.
	localparam int T_WSA_NS   = 15;
	localparam int T_WSC_NS   = 10;
	localparam int T_WP_NS    = 30;
	localparam int T_WSD_NS   = 40;
	localparam int T_WHA_NS   = 5;
	localparam int T_WHD_NS   = 5;
	localparam int T_WHC_NS   = 5;
	localparam int T_AA_NS    = 50;
	localparam int T_CD_NS    = 40;
	localparam int CNT_W      = 5;
	localparam int T_SET_NS   = (T_WSA_NS > T_WSC_NS) ? T_WSA_NS : T_WSC_NS;
	localparam int T_PULSE_NS = (T_WP_NS > T_WSD_NS) ? T_WP_NS : T_WSD_NS;
	localparam int T_HOLD_NS  = (T_WHA_NS > T_WHD_NS) ? ((T_WHA_NS > T_WHC_NS) ? T_WHA_NS : T_WHC_NS)
		: ((T_WHD_NS > T_WHC_NS) ? T_WHD_NS : T_WHC_NS);
	localparam logic [CNT_W-1:0] SET_CYC   = CNT_W'((T_SET_NS * 1000 + CLK_PS - 1) / CLK_PS);
	localparam logic [CNT_W-1:0] PULSE_CYC = CNT_W'((T_PULSE_NS * 1000 + CLK_PS - 1) / CLK_PS);
	localparam logic [CNT_W-1:0] HOLD_CYC  = CNT_W'((T_HOLD_NS * 1000 + CLK_PS - 1) / CLK_PS);
	localparam logic [CNT_W-1:0] ACC_CYC   = CNT_W'((T_AA_NS * 1000 + CLK_PS - 1) / CLK_PS);
	localparam logic [CNT_W-1:0] OFF_CYC   = CNT_W'((T_CD_NS * 1000 + CLK_PS - 1) / CLK_PS);
	// Margin for the three-stage pin synchroniser.
	localparam logic [CNT_W-1:0] SYNC_CYC  = CNT_W'(3);
	localparam logic [CNT_W-1:0] CNT_ONE   = CNT_W'(1);
	localparam logic [CNT_W-1:0] CNT_ZERO  = CNT_W'(0);
	localparam logic [CE_N-1:0]  CE_ON     = 3'h0;
	localparam logic [CE_N-1:0]  CE_OFF    = 3'h7;
	typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_PULSE, ST_HOLD, ST_ACCESS, ST_RECOVER} brc_state_t;
endpackage

// ==== pkg/brc_sync_if.sv ====
// Interface between the controller and its pin synchroniser.
// Assumes both ends share mclk.
`timescale 1ns/1ps
interface brc_sync_if;
	logic rawIn;
	logic syncOut;
	modport src (output rawIn, input syncOut);
	modport snk (input rawIn, output syncOut);
endinterface

// ==== hdl/brc_sync.sv ====
// Three-stage synchroniser for the memory's data output pin.
// Assumes an active-low asynchronous reset already released in the mclk domain.
`timescale 1ns/1ps
module brc_sync (
	input  wire logic mclk,
	input  wire logic rstN,
	input  wire logic clkEn,
	brc_sync_if.snk   sif
);
	logic s1_q, s2_q, s3_q, out_q;
	logic s1_d, s2_d, s3_d, out_d;
	always_comb begin
		s1_d  = clkEn ? sif.rawIn : s1_q;
		s2_d  = clkEn ? s1_q : s2_q;
		s3_d  = clkEn ? s2_q : s3_q;
		out_d = (clkEn && (s2_q == s3_q)) ? s3_q : out_q;
	end
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			s1_q  <= 1'b0;
			s2_q  <= 1'b0;
			s3_q  <= 1'b0;
			out_q <= 1'b0;
		end else begin
			s1_q  <= s1_d;
			s2_q  <= s2_d;
			s3_q  <= s3_d;
			out_q <= out_d;
		end
	end
	assign sif.syncOut = out_q;
endmodule

// ==== sim/brc_ram_model.sv ====
// Behavioural model of the 256 x 1 RAM with inverting three-state output.
// Assumes the controller drives its pins straight into these ports.
`timescale 1ns/1ps
module brc_ram_model
	import brc_pkg::*;
(
	input  wire logic [brc_pkg::ADDR_W-1:0] ramAddr,
	input  wire logic [brc_pkg::CE_N-1:0]   ramCeN,
	input  wire logic                       ramWeN,
	input  wire logic                       ramDin,
	output logic                            ramDoutN
);
	import brc_pkg::*;
	logic cells [CELLS];
	initial ramDoutN = 1'b0;
	always @(ramAddr or ramCeN or ramWeN or ramDin) begin
		if (ramCeN == CE_ON && !ramWeN) begin
			cells[ramAddr] = ramDin;
			ramDoutN = ~ramDin;
		end else if (ramCeN == CE_ON) begin
			ramDoutN = ~cells[ramAddr];
		end else begin
			ramDoutN = ~ramDoutN;
		end
	end
endmodule

// ==== sim/brc_ctrl_properties.sv ====
// Checker on the controller's RAM pins and request port.
// Assumes it is bound into brc_ctrl.
`timescale 1ns/1ps
module brc_ctrl_properties
	import brc_pkg::*;
(
	input wire logic                       mclk,
	input wire logic                       resetn,
	input wire logic                       clkEn,
	input wire logic                       reqValid,
	input wire logic                       reqReady,
	input wire logic                       reqWrite,
	input wire logic                       rspValid,
	input wire logic                       wrCheckErr,
	input wire logic [brc_pkg::ADDR_W-1:0] ramAddr,
	input wire logic [brc_pkg::CE_N-1:0]   ramCeN,
	input wire logic                       ramWeN,
	input wire logic                       ramDin
);
	import brc_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn || !clkEn);
	property p_weSel; !ramWeN |-> ramCeN == CE_ON; endproperty
	a_weSel: assert property (p_weSel) else $error("strobe low while not selected");
	property p_setup; $fell(ramWeN) |-> $past(ramCeN, 3) == CE_ON && $past(ramAddr, 3) == ramAddr; endproperty
	a_setup: assert property (p_setup) else $error("select or address late before strobe");
	property p_pulse; $fell(ramWeN) |-> !ramWeN [*8]; endproperty
	a_pulse: assert property (p_pulse) else $error("strobe pulse too short");
	property p_endHold; $rose(ramWeN) |-> ramCeN == CE_ON && $stable(ramAddr) && $stable(ramDin); endproperty
	a_endHold: assert property (p_endHold) else $error("pins moved at strobe end");
	property p_noErr; !wrCheckErr; endproperty
	a_noErr: assert property (p_noErr) else $error("write check flagged");
	property p_rdLat; reqValid && reqReady && !reqWrite |-> ##14 rspValid; endproperty
	a_rdLat: assert property (p_rdLat) else $error("read answer late");
	property p_wrLat; reqValid && reqReady && reqWrite |-> ##24 rspValid; endproperty
	a_wrLat: assert property (p_wrLat) else $error("write answer late");
	property p_idle; reqReady |-> ramCeN == CE_OFF && ramWeN; endproperty
	a_idle: assert property (p_idle) else $error("pins active while idle");
endmodule
bind brc_ctrl brc_ctrl_properties u_chk (.mclk, .resetn, .clkEn, .reqValid, .reqReady, .reqWrite, .rspValid,
	.wrCheckErr, .ramAddr, .ramCeN, .ramWeN, .ramDin);

// ==== sim/tb_top.sv ====
// Self-checking bench for the bit RAM host controller.
// Assumes the RAM model and the bound checker.
`timescale 1ns/1ps
module tb_top;
	import brc_pkg::*;
	logic              mclk = 1'b0, resetn = 1'b0, clkEn = 1'b1;
	logic              reqValid = 1'b0, reqWrite = 1'b0, reqData = 1'b0;
	logic [ADDR_W-1:0] reqAddr = 8'h00;
	logic              reqReady, rspValid, rspData, wrCheckErr, ramWeN, ramDin, ramDoutN, q;
	logic [ADDR_W-1:0] ramAddr;
	logic [CE_N-1:0]   ramCeN;
	int                error_cnt = 0, num_checks = 0;
	logic              errSeen = 1'b0;
	logic [7:0]        addrs [6] = '{8'h00, 8'h01, 8'h7f, 8'h80, 8'hfe, 8'hff};
	initial forever #2.5 mclk = ~mclk;
	brc_ctrl dut (.mclk, .resetn, .clkEn, .reqValid, .reqReady, .reqWrite, .reqAddr, .reqData, .rspValid,
		.rspData, .wrCheckErr, .ramAddr, .ramCeN, .ramWeN, .ramDin, .ramDoutN);
	brc_ram_model ram (.ramAddr, .ramCeN, .ramWeN, .ramDin, .ramDoutN);
	always @(negedge mclk) if (resetn && wrCheckErr !== 1'b0) errSeen = 1'b1;
	task automatic end_of_test;
		$display("Checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic d, output logic r);
		int n;
		n = 0;
		do @(negedge mclk); while (!reqReady && ++n < 100);
		reqValid = 1'b1;
		reqWrite = w;
		reqAddr = a;
		reqData = d;
		@(negedge mclk);
		reqValid = 1'b0;
		n = 0;
		do @(negedge mclk); while (!rspValid && ++n < 100);
		r = rspData;
		if (n >= 100) check(8'h01, 8'h00);
	endtask
	task automatic t_idle_pins;
		check(8'(ramCeN), 8'(CE_OFF));
		check(8'(ramWeN), 8'h01);
	endtask
	task automatic t_write_read;
		foreach (addrs[i]) xfer(1'b1, addrs[i], addrs[i][0] ^ addrs[i][7], q);
		foreach (addrs[i]) begin
			xfer(1'b0, addrs[i], 1'b0, q);
			check(8'(q), 8'(addrs[i][0] ^ addrs[i][7]));
			xfer(1'b0, addrs[i], 1'b0, q);
			check(8'(q), 8'(addrs[i][0] ^ addrs[i][7]));
		end
	endtask
	task automatic t_overwrite;
		xfer(1'b1, 8'h55, 1'b1, q);
		xfer(1'b1, 8'h55, 1'b0, q);
		xfer(1'b0, 8'h55, 1'b1, q);
		check(8'(q), 8'h00);
		xfer(1'b1, 8'h55, 1'b1, q);
		xfer(1'b0, 8'h55, 1'b0, q);
		check(8'(q), 8'h01);
		check(8'(errSeen), 8'h00);
	endtask
	task automatic t_freeze;
		int n;
		n = 0;
		do @(negedge mclk); while (!reqReady && ++n < 100);
		reqValid = 1'b1;
		reqWrite = 1'b0;
		reqAddr = 8'h01;
		@(negedge mclk);
		reqValid = 1'b0;
		clkEn = 1'b0;
		repeat (20) @(negedge mclk);
		check(8'(ramCeN), 8'(CE_ON));
		check(8'(rspValid), 8'h00);
		clkEn = 1'b1;
		n = 0;
		do @(negedge mclk); while (!rspValid && ++n < 100);
		clkEn = 1'b0;
		repeat (4) @(negedge mclk);
		check(8'(rspValid), 8'h01);
		check(8'(rspData), 8'h01);
		clkEn = 1'b1;
		@(negedge mclk);
	endtask
	initial begin
		#20000;
		error_cnt++;
		end_of_test();
	end
	initial begin
		repeat (16) @(negedge mclk);
		t_idle_pins();
		resetn = 1'b1;
		t_write_read();
		t_overwrite();
		t_freeze();
		t_idle_pins();
		end_of_test();
	end
endmodule
